// *** sar_adc_control_regs.sv ***
// Control, sequencing and CPU register logic of a 10-bit eight-input ADC
//
// How it works
// - 10-bit result: high byte, low bits 7:6
// - Results clear on reset and standby
// - Result goes to register paired with channel
// - Done flag set at single or sweep end
// - Done clears by zero-write after set read
// - Bit 6 gates the done interrupt
// - Run bit starts; single mode self-clears
// - Sweep repeats until run cleared
// - Enabled falling pin edge sets run
// - Bit 4 selects single or sweep
// - Bit 3 selects 266 or 134 states
// - Single mode: bits 2:0 give input
// - Sweep: group bit, count minus one
// - Control/status clears on reset and standby
// - Trigger bits 6:0 read one; reset 7f
// - High-byte read latches low byte
// - Low-byte read returns the latch
// - Interrupt when done set and enabled
// - Sweep starts at group's first input
// - Later sweep conversions take 256 or 118
`default_nettype none
module sar_adc_control_regs (
   // Clock, reset and standby
   input wire logic clk,
   input wire logic rst,
   input wire logic standby,
   // CPU byte bus, one-cycle strobes
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   // External start pin
   input wire logic ext_start_pin,
   // Conversion core
   output logic core_start,
   output logic [2:0] core_channel,
   output logic [8:0] core_time,
   input wire logic core_done,
   input wire logic [9:0] core_result,
   // Interrupt request
   output logic conv_done_irq
);
   typedef struct packed {
      adc_ctrl_pkg::seq_state_t state;
      logic [9:0] res_a;
      logic [9:0] res_b;
      logic [9:0] res_c;
      logic [9:0] res_d;
      logic [7:0] low_latch;
      logic done_flag;
      logic done_seen;
      logic irq_en;
      logic run;
      logic sweep;
      logic speed;
      logic [2:0] chan_sel;
      logic ext_en;
      logic first_conv;
      logic [1:0] sweep_idx;
      logic [7:0] rdata;
      logic start;
      logic [2:0] channel;
      logic [8:0] ctime;
      logic irq;
   } ctrl_t;

   ctrl_t st_reg;
   ctrl_t st_next;
   logic ext_fall;

   // Falling-edge detect on the start pin, dropped during standby
   start_edge_sync u_start_sync (
      .clk(clk),
      .rst(rst),
      .clear(standby),
      .pin_in(ext_start_pin),
      .fall_pulse(ext_fall)
   );

   // Read value of the control/status register
   function automatic logic [7:0] csr_value(input ctrl_t s);
      csr_value = {s.done_flag, s.irq_en, s.run, s.sweep, s.speed,
                   s.chan_sel};
   endfunction

   // Read value of a result low byte field
   function automatic logic [7:0] low_byte(input logic [9:0] r);
      low_byte = {r[1:0], 6'h00};
   endfunction

   // Conversion time for the current request
   function automatic logic [8:0] conv_time(input logic speed,
                                            input logic first);
      if (first)
      begin
         conv_time = speed ? adc_ctrl_pkg::first_conv_fast_cycles
                           : adc_ctrl_pkg::first_conv_slow_cycles;
      end
      else
      begin
         conv_time = speed ? adc_ctrl_pkg::next_conv_fast_cycles
                           : adc_ctrl_pkg::next_conv_slow_cycles;
      end
   endfunction

   // Next-state logic: bus access, sequencing, results
   always_comb
   begin
      logic [2:0] done_ch;
      logic set_done;
      logic end_seq;
      logic run_rise;
      done_ch = st_reg.channel;
      set_done = 1'b0;
      end_seq = 1'b0;
      run_rise = 1'b0;
      st_next = st_reg;
      st_next.start = 1'b0;
      st_next.rdata = 8'h00;

      // CPU reads; unmapped addresses return zero
      if (cpu_rd)
      begin
         case (cpu_addr)
            adc_ctrl_pkg::off_result_a_high:
            begin
               st_next.rdata = st_reg.res_a[9:2];
               st_next.low_latch = low_byte(st_reg.res_a);
            end
            adc_ctrl_pkg::off_result_b_high:
            begin
               st_next.rdata = st_reg.res_b[9:2];
               st_next.low_latch = low_byte(st_reg.res_b);
            end
            adc_ctrl_pkg::off_result_c_high:
            begin
               st_next.rdata = st_reg.res_c[9:2];
               st_next.low_latch = low_byte(st_reg.res_c);
            end
            adc_ctrl_pkg::off_result_d_high:
            begin
               st_next.rdata = st_reg.res_d[9:2];
               st_next.low_latch = low_byte(st_reg.res_d);
            end
            adc_ctrl_pkg::off_result_a_low,
            adc_ctrl_pkg::off_result_b_low,
            adc_ctrl_pkg::off_result_c_low,
            adc_ctrl_pkg::off_result_d_low:
               st_next.rdata = st_reg.low_latch;
            adc_ctrl_pkg::off_conv_control_status:
            begin
               st_next.rdata = csr_value(st_reg);
               if (st_reg.done_flag)
               begin
                  st_next.done_seen = 1'b1;
               end
            end
            adc_ctrl_pkg::off_trigger_control:
               st_next.rdata = {st_reg.ext_en, 7'h00}
                               | adc_ctrl_pkg::trigger_ro_ones;
            default:
               st_next.rdata = 8'h00;
         endcase
      end

      // CPU writes; result bytes are read-only and ignore writes
      if (cpu_wr)
      begin
         case (cpu_addr)
            adc_ctrl_pkg::off_conv_control_status:
            begin
               if (!cpu_wdata[adc_ctrl_pkg::conv_done_flag_bit]
                   && st_reg.done_seen)
               begin
                  st_next.done_flag = 1'b0;
                  st_next.done_seen = 1'b0;
               end
               st_next.irq_en =
                  cpu_wdata[adc_ctrl_pkg::done_irq_enable_bit];
               st_next.run = cpu_wdata[adc_ctrl_pkg::conv_run_bit];
               st_next.sweep =
                  cpu_wdata[adc_ctrl_pkg::sweep_mode_bit];
               st_next.speed =
                  cpu_wdata[adc_ctrl_pkg::conv_speed_select_bit];
               st_next.chan_sel = cpu_wdata[2:0];
               run_rise = cpu_wdata[adc_ctrl_pkg::conv_run_bit]
                          & ~st_reg.run;
            end
            adc_ctrl_pkg::off_trigger_control:
               st_next.ext_en =
                  cpu_wdata[adc_ctrl_pkg::ext_start_enable_bit];
            default:
               st_next.ext_en = st_next.ext_en;
         endcase
      end

      // Enabled falling edge on the pin acts as a software start
      if (st_reg.ext_en && ext_fall && !st_next.run)
      begin
         st_next.run = 1'b1;
         run_rise = 1'b1;
      end

      // Conversion sequencer
      case (st_reg.state)
         adc_ctrl_pkg::st_idle:
         begin
            if (st_next.run)
            begin
               st_next.state = adc_ctrl_pkg::st_wait;
            end
         end
         adc_ctrl_pkg::st_wait:
         begin
            // First channel of a new start
            st_next.first_conv = 1'b1;
            st_next.sweep_idx = 2'h0;
            st_next.channel = st_reg.sweep
               ? {st_reg.chan_sel[adc_ctrl_pkg::group_select_bit], 2'h0}
               : st_reg.chan_sel;
            st_next.ctime = conv_time(st_reg.speed, 1'b1);
            st_next.start = st_next.run;
            st_next.state = st_next.run ? adc_ctrl_pkg::st_busy
                                        : adc_ctrl_pkg::st_idle;
         end
         adc_ctrl_pkg::st_busy:
         begin
            if (core_done)
            begin
               // Store into the register paired with the channel
               case (done_ch[1:0])
                  2'h0: st_next.res_a = core_result;
                  2'h1: st_next.res_b = core_result;
                  2'h2: st_next.res_c = core_result;
                  default: st_next.res_d = core_result;
               endcase
               if (!st_reg.sweep)
               begin
                  set_done = 1'b1;
                  end_seq = 1'b1;
                  st_next.run = 1'b0;
               end
               else
               begin
                  if (st_reg.sweep_idx == st_reg.chan_sel[1:0])
                  begin
                     set_done = 1'b1;
                     st_next.sweep_idx = 2'h0;
                  end
                  else
                  begin
                     st_next.sweep_idx = st_reg.sweep_idx + 2'h1;
                  end
                  st_next.channel =
                     {st_reg.chan_sel[adc_ctrl_pkg::group_select_bit],
                      st_next.sweep_idx};
                  st_next.first_conv = 1'b0;
                  st_next.ctime = conv_time(st_reg.speed, 1'b0);
                  st_next.start = st_next.run;
                  end_seq = !st_next.run;
               end
            end
            // Software stop or restart abandons the conversion
            if (!st_next.run || run_rise)
            begin
               st_next.start = 1'b0;
               end_seq = 1'b1;
            end
            if (end_seq)
            begin
               st_next.state = st_next.run ? adc_ctrl_pkg::st_wait
                                           : adc_ctrl_pkg::st_idle;
            end
         end
         default:
            st_next.state = adc_ctrl_pkg::st_idle;
      endcase

      // Hardware set wins over a clear in the same cycle
      if (set_done)
      begin
         st_next.done_flag = 1'b1;
         st_next.done_seen = 1'b0;
      end
      st_next.irq = st_next.done_flag & st_next.irq_en;
   end

   // State register; standby acts like reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.state <= adc_ctrl_pkg::st_idle;
         st_reg.ext_en <= adc_ctrl_pkg::trigger_control_reset[7];
      end
      else if (standby)
      begin
         st_reg <= '0;
         st_reg.state <= adc_ctrl_pkg::st_idle;
         st_reg.ext_en <= adc_ctrl_pkg::trigger_control_reset[7];
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flip-flops
   assign cpu_rdata = st_reg.rdata;
   assign core_start = st_reg.start;
   assign core_channel = st_reg.channel;
   assign core_time = st_reg.ctime;
   assign conv_done_irq = st_reg.irq;
endmodule
`default_nettype wire

// *** adc_ctrl_pkg.sv ***
// Package holding register map, field positions, reset values and timings
`default_nettype none
package adc_ctrl_pkg;
   // Register offsets (lower 16 bits of the address)
   localparam logic [15:0] off_result_a_high = 16'hffe0;
   localparam logic [15:0] off_result_a_low = 16'hffe1;
   localparam logic [15:0] off_result_b_high = 16'hffe2;
   localparam logic [15:0] off_result_b_low = 16'hffe3;
   localparam logic [15:0] off_result_c_high = 16'hffe4;
   localparam logic [15:0] off_result_c_low = 16'hffe5;
   localparam logic [15:0] off_result_d_high = 16'hffe6;
   localparam logic [15:0] off_result_d_low = 16'hffe7;
   localparam logic [15:0] off_conv_control_status = 16'hffe8;
   localparam logic [15:0] off_trigger_control = 16'hffe9;
   // Control/status and trigger control field positions
   localparam int conv_done_flag_bit = 7;
   localparam int done_irq_enable_bit = 6;
   localparam int conv_run_bit = 5;
   localparam int sweep_mode_bit = 4;
   localparam int conv_speed_select_bit = 3;
   localparam int group_select_bit = 2;
   localparam int ext_start_enable_bit = 7;
   // Reset values and the trigger read-only ones mask
   localparam logic [7:0] conv_control_status_reset = 8'h00;
   localparam logic [7:0] trigger_control_reset = 8'h7f;
   localparam logic [9:0] result_reset = 10'h000;
   localparam logic [7:0] trigger_ro_ones = 8'h7f;
   // Conversion times in states (one state is one clk cycle)
   localparam int first_conv_slow_states = 266;
   localparam int first_conv_fast_states = 134;
   localparam int next_conv_slow_states = 256;
   localparam int next_conv_fast_states = 118;
   localparam int clk_period_ns = 100;
   localparam int state_period_ns = 100;
   localparam int states_per_cycle = state_period_ns / clk_period_ns;
   localparam logic [8:0] first_conv_slow_cycles =
      9'(first_conv_slow_states * states_per_cycle);
   localparam logic [8:0] first_conv_fast_cycles =
      9'(first_conv_fast_states * states_per_cycle);
   localparam logic [8:0] next_conv_slow_cycles =
      9'(next_conv_slow_states * states_per_cycle);
   localparam logic [8:0] next_conv_fast_cycles =
      9'(next_conv_fast_states * states_per_cycle);
   // Sequencer states
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_wait = 3'b010,
      st_busy = 3'b100
   } seq_state_t;
endpackage
`default_nettype wire

// *** start_edge_sync.sv ***
// Synchroniser and falling-edge detector for the external start pin
`default_nettype none
module start_edge_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   // Pin and detected edge
   input wire logic pin_in,
   output logic fall_pulse
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic fall;
   } sync_t;
   sync_t st_reg;
   sync_t st_next;

   // Three stages; an edge counts once stages two and three agree on it
   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.fall = 1'b0;
      // Level moves only when stages two and three agree
      if (st_reg.s2 == st_reg.s3)
      begin
         st_next.level = st_reg.s3;
         st_next.fall = st_reg.level & ~st_reg.s3;
      end
      if (clear)
      begin
         st_next.fall = 1'b0;
      end
   end

   // Idle pin level is high
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1,
                     fall: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign fall_pulse = st_reg.fall;
endmodule
`default_nettype wire

// *** adc_core_model.sv ***
// Behavioural conversion core facing the control block
`default_nettype none
module adc_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control side
   input wire logic slow,
   input wire logic start,
   input wire logic [2:0] channel,
   output logic done,
   output logic [9:0] result
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   logic [9:0] last;
   // Count down after a start, then pulse done with a channel code
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt <= 0;
         done <= 1'b0;
         last <= 10'h000;
      end
      else
      begin
         done <= 1'b0;
         if (start)
            cnt <= slow ? 40 : 3;
         else if (cnt != 0)
            cnt <= cnt - 1;
         if (!start && cnt == 1)
         begin
            done <= 1'b1;
            last <= {channel, channel, channel, 1'b1};
         end
      end
   end
   // Result only meaningful with done; inverse shown otherwise
   assign result = done ? last : ~last;
endmodule
`default_nettype wire

// *** sar_adc_control_regs_asserts.sv ***
// Property checker for the converter control and register block
`default_nettype none
module sar_adc_control_regs_asserts (
   // Clock, reset and standby
   input wire logic clk,
   input wire logic rst,
   input wire logic standby,
   // CPU bus
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   // Pin, core and interrupt
   input wire logic ext_start_pin,
   input wire logic core_start,
   input wire logic [2:0] core_channel,
   input wire logic [8:0] core_time,
   input wire logic core_done,
   input wire logic [9:0] core_result,
   input wire logic conv_done_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic csr_sel;
   logic go_wr;
   // Control/status address match, and writes there that set the run bit
   assign csr_sel = cpu_addr == adc_ctrl_pkg::off_conv_control_status;
   assign go_wr = cpu_wr && !standby && csr_sel && cpu_wdata[5];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_trig_ones;
      cpu_rd && cpu_addr == adc_ctrl_pkg::off_trigger_control
         |=> cpu_rdata[6:0] == 7'h7f;
   endproperty
   a_trig_ones: assert property (p_trig_ones)
      else $error("trigger low bits not one");
   property p_low_zero;
      cpu_rd && cpu_addr[15:3] == 13'h1ffc && cpu_addr[0]
         |=> cpu_rdata[5:0] == 6'h00;
   endproperty
   a_low_zero: assert property (p_low_zero)
      else $error("low byte bits 5..0 not zero");
   property p_irq_cause;
      $rose(conv_done_irq) |-> $past(core_done)
         || $past(cpu_wr && csr_sel && cpu_wdata[6]);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt rose without cause");
   property p_start;
      go_wr |-> ##2 core_start;
   endproperty
   a_start: assert property (p_start)
      else $error("run write gave no start");
   property p_single_chan;
      go_wr && !cpu_wdata[4] |-> ##2 core_channel == $past(cpu_wdata[2:0], 2);
   endproperty
   a_single_chan: assert property (p_single_chan)
      else $error("single channel wrong");
   property p_sweep_first;
      go_wr && cpu_wdata[4]
         |-> ##2 core_channel == {$past(cpu_wdata[2], 2), 2'b00};
   endproperty
   a_sweep_first: assert property (p_sweep_first)
      else $error("sweep first channel wrong");
   property p_first_time;
      go_wr |-> ##2 core_time == ($past(cpu_wdata[3], 2)
         ? adc_ctrl_pkg::first_conv_fast_cycles
         : adc_ctrl_pkg::first_conv_slow_cycles);
   endproperty
   a_first_time: assert property (p_first_time)
      else $error("first conversion time wrong");
   property p_start_pulse;
      core_start |=> !core_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start longer than one cycle");
endmodule
bind sar_adc_control_regs sar_adc_control_regs_asserts
   i_sar_adc_control_regs_asserts (.clk, .rst, .standby, .cpu_addr,
   .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .ext_start_pin, .core_start,
   .core_channel, .core_time, .core_done, .core_result, .conv_done_irq);
`default_nettype wire

// *** sar_adc_control_regs_tb_top.sv ***
// Self-checking bench for the converter control and register block
`default_nettype none
module sar_adc_control_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, standby, cpu_rd, cpu_wr, ext_start_pin, slow;
   logic core_start, core_done, conv_done_irq;
   logic [15:0] cpu_addr;
   logic [7:0] cpu_wdata, cpu_rdata, d;
   logic [2:0] core_channel;
   logic [8:0] core_time;
   logic [9:0] core_result;
   int miscompares, check_count, cycles, n;
   logic [2:0] chq[$];
   logic [8:0] tq[$];
   sar_adc_control_regs i_sar_adc_control_regs (.clk, .rst, .standby,
      .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .ext_start_pin,
      .core_start, .core_channel, .core_time, .core_done, .core_result,
      .conv_done_irq);
   adc_core_model i_adc_core_model (.clk, .rst, .slow, .start(core_start),
      .channel(core_channel), .done(core_done), .result(core_result));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Log each start and cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (core_start)
      begin
         chq.push_back(core_channel);
         tq.push_back(core_time);
      end
      if (cycles == 20000)
      begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(negedge clk);
      cpu_addr = a;
      cpu_wdata = v;
      cpu_wr = 1'b1;
      @(negedge clk);
      cpu_wr = 1'b0;
   endtask
   // Plain read into d, no comparison
   task automatic rd(input logic [15:0] a);
      @(negedge clk);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge clk);
      cpu_rd = 1'b0;
      d = cpu_rdata;
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] exp);
      rd(a);
      chk({1'b0, d}, {1'b0, exp});
   endtask
   // Poll control/status until the done flag shows
   task automatic wait_done();
      d = 8'h00;
      for (int i = 0; i < 300 && d[7] !== 1'b1; i++)
         rd(16'hffe8);
   endtask
   task automatic pin_fall();
      ext_start_pin = 1'b0;
      repeat (8) @(negedge clk);
      ext_start_pin = 1'b1;
   endtask
   task automatic reset_vals();
      for (int i = 0; i < 8; i++)
         rc(16'hffe0 + 16'(i), 8'h00);
      rc(16'hffe8, 8'h00);
      rc(16'hffe9, 8'h7f);
      rc(16'hffea, 8'h00);
   endtask
   function automatic logic [7:0] hi(input logic [2:0] c);
      return {c, c, c[2:1]};
   endfunction
   // Main sequence
   initial
   begin
      {rst, standby, cpu_rd, cpu_wr, slow, d} = 13'h1000;
      {cpu_addr, cpu_wdata, ext_start_pin} = 25'h1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      reset_vals();
      for (int c = 0; c < 8; c++)
      begin
         slow = c[0];
         wr(16'hffe8, 8'h20 | 8'(c));
         wait_done();
         chk({1'b0, d}, 9'h080 | 9'(c));
         wr(16'hffe8, 8'(c));
         rc(16'hffe8, 8'(c));
         rc(16'hffe0 + 16'(2 * (c % 4)), hi(3'(c)));
         rc(16'hffe1 + 16'(2 * (c % 4)), {c[0], 7'h40});
      end
      wr(16'hffe8, 8'h80);
      rc(16'hffe8, 8'h00);
      wr(16'hffe6, 8'hff);
      rc(16'hffe6, hi(3'h7));
      wr(16'hffe8, 8'h61);
      wait_done();
      chk({8'h00, conv_done_irq}, 9'h001);
      wr(16'hffe8, 8'h41);
      @(negedge clk);
      chk({8'h00, conv_done_irq}, 9'h000);
      wr(16'hffe8, 8'h21);
      wait_done();
      chk({8'h00, conv_done_irq}, 9'h000);
      chq.delete();
      tq.delete();
      wr(16'hffe8, 8'h3e);
      wait_done();
      for (int i = 0; i < 900 && chq.size() < 5; i++)
         @(negedge clk);
      wr(16'hffe8, 8'h1e);
      n = chq.size();
      repeat (60) @(negedge clk);
      chk(9'(chq.size()), 9'(n));
      for (int i = 0; i < 5; i++)
      begin
         chk({6'h00, chq[i]}, 9'(4 + i % 3));
         chk(tq[i], i == 0 ? 9'd134 : 9'd118);
      end
      rc(16'hffe4, hi(3'h6));
      wr(16'hffe8, 8'h05);
      wr(16'hffe9, 8'h00);
      rc(16'hffe9, 8'h7f);
      pin_fall();
      repeat (10) @(negedge clk);
      rc(16'hffe8, 8'h05);
      wr(16'hffe9, 8'hff);
      rc(16'hffe9, 8'hff);
      pin_fall();
      wait_done();
      chk({1'b0, d}, 9'h085);
      rc(16'hffe2, hi(3'h5));
      standby = 1'b1;
      @(negedge clk);
      standby = 1'b0;
      reset_vals();
      results();
   end
endmodule
`default_nettype wire
